// file: hw/adc_conversion_sequencer.sv
// Conversion sequencer for a 10-bit successive-approximation converter, AXI4-Lite slave.
// Assumes the analog core presents a settled result on ADC_DATA at the final converter cycle.
//
// Function
// - Writing start bit begins conversion; reads one while busy; single mode clears it.
// - Channel written mid-conversion takes effect only after the current conversion.
// - Finished single or accumulated operation sets result-ready; interrupt needs enables.
// - Result-ready flag is set at completion whether or not interrupt enabled.
// - Rising event edge with event input enabled sets start bit; single mode clears it on completion.
// - Free-running: software starts first; later ones follow at once, each sets flag.
// - Prescaler counter runs only while enabled and is zero when disabled.
// - Prescaler held reset when idle; start delay is half factor plus two cycles.
// - With zero sample delay and length, conversion takes 13 converter cycles; sample-and-hold at two cycles after start.
// - Result-ready clears on result read or on writing one to the flag.
// - Sampling lasts 2 plus sample delay plus sample length converter cycles.
// - Free-running period is 13 plus sample delay plus sample length cycles.
// - Channel and reference go through staging; active copy follows it while idle.
// - Active selection locked during conversion, follows again in final cycle.
// - Free-running channel change affects the conversion after next.
// - Input above reference yields full scale code 0x3FF.
// - Reference field picks supply, external reference pin or internal reference.
// - Ten-bit result sits right-adjusted in the result register.
// - Each new readable result emits a one-cycle result-ready event pulse.
// - Interrupt request stands while enabled flag is set, drops when cleared.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic EVENT_START,
	output logic EVENT_RESULT_READY,
	output logic IRQ,
	input wire logic [9:0] ADC_DATA,
	input wire logic ADC_OVERRANGE,
	output logic ADC_ENABLE,
	output logic ADC_SAMPLE,
	output adc_seq_pkg::sel_t ADC_SEL
);
	import adc_seq_pkg::*;

	cfg_t cfg_q, cfg_d;
	logic awh_q, awh_d, wh_q, wh_d, ws_q, ws_d, bv_q, bv_d, rv_q, rv_d;
	logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d, rd_val;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic wr_fire, wr_hit, rd_take, rd_hit, wr_byte;
	seq_state_t st_q, st_d;
	logic start_q, start_d, flag_q, flag_d, evo_q, evo_d, irq_q, irq_d, smp_on_q, smp_on_d;
	logic [5:0] cnt_q, cnt_d, total, shlen;
	logic [6:0] nacc_q, nacc_d;
	logic [15:0] acc_q, acc_d, res_q, res_d, sum;
	logic [9:0] code, scaled;
	sel_t sel_q, sel_d, staged;
	logic tick, evt_rise, cmd_start, trig, flag_clr, last_cyc, locked, done, done_last;

	adc_prescaler u_clock_divider_select (
		.clk(SYS_CLK),
		.rst(RST),
		.run(start_q && cfg_q.en && st_q != ST_IDLE),
		.div_sel(cfg_q.clock_divider_select),
		.tick(tick)
	);
	adc_edge_sync u_evt (
		.clk(SYS_CLK),
		.rst(RST),
		.din(EVENT_START),
		.rise(evt_rise)
	);

	// Bus slave: one write and one read at a time, address and data taken in either order.
	assign wr_fire = awh_q && wh_q && !bv_q;
	assign wr_byte = wr_fire && ws_q;
	assign rd_take = S_AXI_ARVALID && arr_q;
	assign wr_hit = (awa_q[1:0] == 2'h0) && (awa_q <= `OFS_STATUS);
	always_comb begin
		rd_hit = (S_AXI_ARADDR[1:0] == 2'h0);
		rd_val = 32'h0000_0000;
		case (S_AXI_ARADDR)
			`OFS_CONTROL_A: rd_val[2:0] = {cfg_q.resolution_select,
				cfg_q.continuous_conversion_enable, cfg_q.en};
			`OFS_CTRLB: rd_val[2:0] = cfg_q.accumulation_count_select;
			`OFS_CONTROL_C: rd_val[6:0] = {1'b0, cfg_q.reference_source_select, 1'b0,
				cfg_q.clock_divider_select};
			`OFS_CTRLD: rd_val[3:0] = cfg_q.sample_delay_count;
			`OFS_SAMPCTRL: rd_val[4:0] = cfg_q.sample_length_count;
			`OFS_MUX: rd_val[4:0] = cfg_q.input_channel_select;
			`OFS_COMMAND: rd_val[0] = start_q;
			`OFS_EVCTRL: rd_val[0] = cfg_q.start_event_input_enable;
			`OFS_IRQ_ENABLE: rd_val[0] = cfg_q.irq_en;
			`OFS_IRQ_FLAG: rd_val[0] = flag_q;
			`OFS_RESULT: rd_val[15:0] = res_q;
			`OFS_STATUS: rd_val[9:0] = {st_q != ST_IDLE, sel_q, smp_on_q, start_q};
			default: rd_hit = 1'b0;
		endcase
	end
	always_comb begin
		awh_d = awh_q;
		awa_d = awa_q;
		wh_d = wh_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		bresp_d = bresp_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rresp_d = rresp_q;
		if (S_AXI_AWVALID && awr_q) begin
			awh_d = 1'b1;
			awa_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wr_q) begin
			wh_d = 1'b1;
			wd_d = S_AXI_WDATA;
			ws_d = S_AXI_WSTRB[0];
		end
		if (wr_fire) begin
			awh_d = 1'b0;
			wh_d = 1'b0;
			bv_d = 1'b1;
			bresp_d = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bv_q && S_AXI_BREADY) begin
			bv_d = 1'b0;
		end
		if (rd_take) begin
			rv_d = 1'b1;
			rd_d = rd_val;
			rresp_d = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rv_q && S_AXI_RREADY) begin
			rv_d = 1'b0;
		end
		awr_d = !awh_d && !bv_d;
		wr_d = !wh_d && !bv_d;
		arr_d = !rv_d;
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			awh_q <= 1'b0;
			awa_q <= 8'h00;
			wh_q <= 1'b0;
			wd_q <= 32'h0000_0000;
			ws_q <= 1'b0;
			bv_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			rv_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			arr_q <= 1'b0;
		end else begin
			awh_q <= awh_d;
			awa_q <= awa_d;
			wh_q <= wh_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			bresp_q <= bresp_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rresp_q <= rresp_d;
			awr_q <= awr_d;
			wr_q <= wr_d;
			arr_q <= arr_d;
		end
	end

	// Configuration registers; all fields sit in byte lane 0.
	always_comb begin
		cfg_d = cfg_q;
		if (wr_byte) begin
			case (awa_q)
				`OFS_CONTROL_A: begin
					cfg_d.en = wd_q[`BIT_ENABLE];
					cfg_d.continuous_conversion_enable = wd_q[`BIT_CONT];
					cfg_d.resolution_select = wd_q[`BIT_RES8];
				end
				`OFS_CTRLB: cfg_d.accumulation_count_select = wd_q[2:0];
				`OFS_CONTROL_C: begin
					cfg_d.reference_source_select = wd_q[`LSB_REF +: 2];
					cfg_d.clock_divider_select = wd_q[2:0];
				end
				`OFS_CTRLD: cfg_d.sample_delay_count = wd_q[3:0];
				`OFS_SAMPCTRL: cfg_d.sample_length_count = wd_q[4:0];
				`OFS_MUX: cfg_d.input_channel_select = wd_q[4:0];
				`OFS_EVCTRL: cfg_d.start_event_input_enable = wd_q[0];
				`OFS_IRQ_ENABLE: cfg_d.irq_en = wd_q[0];
				default: cfg_d = cfg_q;
			endcase
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			cfg_q <= cfg_t'(27'(`RST_REG));
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Sequencer. Accumulated samples are summed; the flag marks the end of the whole burst.
	assign cmd_start = wr_byte && awa_q == `OFS_COMMAND && wd_q[0];
	assign trig = cfg_q.en && (cmd_start || (cfg_q.start_event_input_enable && evt_rise));
	assign flag_clr = (wr_byte && awa_q == `OFS_IRQ_FLAG && wd_q[0])
		|| (rd_take && S_AXI_ARADDR == `OFS_RESULT);
	assign total = `CONV_CYCLES + 6'(cfg_q.sample_delay_count) + 6'(cfg_q.sample_length_count);
	assign shlen = `SH_CYCLES + 6'(cfg_q.sample_delay_count) + 6'(cfg_q.sample_length_count);
	assign last_cyc = cnt_q == total - 6'h01;
	assign locked = st_q == ST_RUN && !last_cyc;
	assign done = st_q == ST_RUN && tick && last_cyc;
	assign done_last = done && nacc_q == 7'(7'h01 << cfg_q.accumulation_count_select) - 7'h01;
	assign code = ADC_OVERRANGE ? `FULL_SCALE : ADC_DATA;
	assign scaled = cfg_q.resolution_select ? {2'h0, code[9:2]} : code;
	assign sum = acc_q + 16'(scaled);
	assign staged = '{cfg_q.input_channel_select, cfg_q.reference_source_select};
	always_comb begin
		st_d = st_q;
		start_d = start_q;
		cnt_d = cnt_q;
		nacc_d = nacc_q;
		acc_d = acc_q;
		res_d = res_q;
		flag_d = flag_q;
		evo_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (trig) begin
					start_d = 1'b1;
					st_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tick) begin
					st_d = ST_RUN;
					cnt_d = 6'h00;
				end
			end
			ST_RUN: begin
				if (done) begin
					cnt_d = 6'h00;
					if (done_last) begin
						res_d = sum;
						acc_d = 16'h0000;
						nacc_d = 7'h00;
						evo_d = 1'b1;
						if (!cfg_q.continuous_conversion_enable) begin
							start_d = 1'b0;
							st_d = ST_IDLE;
						end
					end else begin
						acc_d = sum;
						nacc_d = nacc_q + 7'h01;
					end
				end else if (tick) begin
					cnt_d = cnt_q + 6'h01;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (!cfg_q.en) begin
			st_d = ST_IDLE;
			start_d = 1'b0;
			cnt_d = 6'h00;
			nacc_d = 7'h00;
			acc_d = 16'h0000;
		end
		if (flag_clr) begin
			flag_d = 1'b0;
		end
		if (done_last) begin
			flag_d = 1'b1;
		end
		sel_d = locked ? sel_q : staged;
		smp_on_d = st_d == ST_RUN && cnt_d < shlen;
		irq_d = flag_d && cfg_d.irq_en;
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_q <= ST_IDLE;
			start_q <= 1'b0;
			cnt_q <= 6'h00;
			nacc_q <= 7'h00;
			acc_q <= 16'h0000;
			res_q <= 16'h0000;
			flag_q <= 1'b0;
			evo_q <= 1'b0;
			irq_q <= 1'b0;
			smp_on_q <= 1'b0;
			sel_q <= sel_t'(7'h00);
		end else begin
			st_q <= st_d;
			start_q <= start_d;
			cnt_q <= cnt_d;
			nacc_q <= nacc_d;
			acc_q <= acc_d;
			res_q <= res_d;
			flag_q <= flag_d;
			evo_q <= evo_d;
			irq_q <= irq_d;
			smp_on_q <= smp_on_d;
			sel_q <= sel_d;
		end
	end

	assign S_AXI_AWREADY = awr_q;
	assign S_AXI_WREADY = wr_q;
	assign S_AXI_BVALID = bv_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arr_q;
	assign S_AXI_RVALID = rv_q;
	assign S_AXI_RDATA = rd_q;
	assign S_AXI_RRESP = rresp_q;
	assign EVENT_RESULT_READY = evo_q;
	assign IRQ = irq_q;
	assign ADC_ENABLE = cfg_q.en;
	assign ADC_SAMPLE = smp_on_q;
	assign ADC_SEL = sel_q;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	a_flag_on_done: assert property (done_last |=> flag_q)
		else $error("flag not set at completion");
	a_flag_cleared: assert property (flag_clr && !done_last |=> !flag_q)
		else $error("flag not cleared");
	a_irq_tracks: assert property (irq_q == (flag_q && cfg_q.irq_en))
		else $error("irq does not follow flag");
	a_sel_locked: assert property (locked |=> $stable(sel_q))
		else $error("selection moved while locked");
	a_free_run: assert property (done_last && cfg_q.en && cfg_q.continuous_conversion_enable
		|=> st_q == ST_RUN && start_q)
		else $error("free-running did not restart");
	a_single_end: assert property (done_last && !cfg_q.continuous_conversion_enable
		|=> !start_q && st_q == ST_IDLE)
		else $error("start bit not cleared");
	a_full_scale: assert property (done_last && ADC_OVERRANGE
		&& cfg_q.accumulation_count_select == 3'h0 && !cfg_q.resolution_select
		|=> res_q == 16'h03FF)
		else $error("overrange not full scale");
	a_event_pulse: assert property (evo_q |=> !evo_q)
		else $error("event pulse too long");
	a_disable_abort: assert property (!cfg_q.en && !flag_clr |=> !start_q && $stable(flag_q))
		else $error("disable did not abort");
	a_start_delay: assert property (st_q == ST_IDLE && trig && cfg_q.clock_divider_select == 3'h0
		&& cfg_q.en |=> ##2 st_q == ST_RUN)
		else $error("start delay wrong");
	c_single: cover property (done_last && !cfg_q.continuous_conversion_enable);
	c_free_run: cover property (done_last && cfg_q.continuous_conversion_enable);
	c_event: cover property (st_q == ST_IDLE && evt_rise && cfg_q.start_event_input_enable);
endmodule : adc_conversion_sequencer

// file: hw/adc_edge_sync.sv
// Two-flop synchroniser with rising-edge detection for the start event.
// Assumes the event input is asynchronous to clk.
`timescale 1ns/1ps
module adc_edge_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic rise
);
	logic [2:0] sh_q, sh_d;
	logic rise_q, rise_d;
	always_comb begin
		sh_d = {sh_q[1:0], din};
		rise_d = sh_q[1] && !sh_q[2];
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_q <= 3'h0;
			rise_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			rise_q <= rise_d;
		end
	end
	assign rise = rise_q;
endmodule : adc_edge_sync

// file: hw/adc_prescaler.sv
// Converter clock prescaler: one-cycle tick at each rising converter-clock edge.
// Assumes run is low whenever no conversion is under way or the converter is off.
`timescale 1ns/1ps
module adc_prescaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] div_sel,
	output logic tick
);
	logic [7:0] cnt_q, cnt_d, half;
	logic tick_q, tick_d;
	// Division factor is 2 << div_sel; the rising edge falls half way through the count.
	assign half = 8'h01 << div_sel;
	always_comb begin
		cnt_d = run ? cnt_q + 8'h01 : 8'h00;
		if (cnt_d == (half << 1)) begin
			cnt_d = 8'h00;
		end
		tick_d = run && (cnt_q == half - 8'h01);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign tick = tick_q;
endmodule : adc_prescaler

// file: hw/adc_seq_cfg.svh
// Offsets, field positions, reset values and timing counts of the conversion sequencer.
// Included by the sequencer module and by the testbench; definitions only.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define OFS_CONTROL_A 8'h00
`define OFS_CTRLB 8'h04
`define OFS_CONTROL_C 8'h08
`define OFS_CTRLD 8'h0C
`define OFS_SAMPCTRL 8'h10
`define OFS_MUX 8'h14
`define OFS_COMMAND 8'h18
`define OFS_EVCTRL 8'h1C
`define OFS_IRQ_ENABLE 8'h20
`define OFS_IRQ_FLAG 8'h24
`define OFS_RESULT 8'h28
`define OFS_STATUS 8'h2C
`define BIT_ENABLE 0
`define BIT_CONT 1
`define BIT_RES8 2
`define LSB_REF 4
`define RST_REG 8'h00
`define CONV_CYCLES 6'h0D
`define SH_CYCLES 6'h02
`define FULL_SCALE 10'h3FF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: hw/adc_seq_pkg.sv
// Types shared by the conversion sequencer modules.
// Assumes the constants header sits beside it.
package adc_seq_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;
	typedef struct packed {
		logic [4:0] input_channel_select;
		logic [1:0] reference_source_select;
	} sel_t;
	typedef struct packed {
		logic en;
		logic continuous_conversion_enable;
		logic resolution_select;
		logic [2:0] accumulation_count_select;
		logic [1:0] reference_source_select;
		logic [2:0] clock_divider_select;
		logic [3:0] sample_delay_count;
		logic [4:0] sample_length_count;
		logic [4:0] input_channel_select;
		logic start_event_input_enable;
		logic irq_en;
	} cfg_t;
endpackage : adc_seq_pkg

// file: verification/adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer, driven over its register port.
// Assumes the design files and the analog core model are compiled before it.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module adc_conversion_sequencer_tb;
	import adc_seq_pkg::*;
	typedef struct {int dv; int dl; int ln; logic [4:0] ch; logic [1:0] rf;
		logic ov; logic ie; logic [9:0] res;} row_t;
	row_t rows[4] = '{'{0, 0, 0, 5'h03, 2'h0, 1'b0, 1'b0, 10'h074},
		'{1, 2, 3, 5'h1F, 2'h1, 1'b0, 1'b1, 10'h3F5},
		'{2, 15, 31, 5'h0A, 2'h2, 1'b1, 1'b1, 10'h3FF},
		'{3, 1, 0, 5'h10, 2'h2, 1'b0, 1'b0, 10'h216}};
	logic sys_clk = 1'b0, rst = 1'b1, aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
	logic ar_valid = 1'b0, r_ready = 1'b0, ev_start = 1'b0, over_req = 1'b0, samp_prev = 1'b0;
	logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
	logic [31:0] w_data = 32'h0, r_data;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid, ev_res, irq, adc_en, adc_samp, adc_over;
	logic [1:0] b_resp, r_resp;
	logic [9:0] adc_data;
	sel_t adc_sel;
	int num_errors = 0, checks = 0, cyc = 0, t_aw = 0, t_samp = 0, samp_cyc = 0;
	int ev_cnt = 0, t_ev = 0, t_ev_prev = 0, base, e0, f;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		samp_prev <= adc_samp;
		if (adc_samp) samp_cyc <= samp_cyc + 1;
		if (adc_samp && !samp_prev) t_samp <= cyc;
		if (ev_res) begin
			ev_cnt <= ev_cnt + 1;
			t_ev_prev <= t_ev;
			t_ev <= cyc;
		end
	end
	adc_conversion_sequencer adc_conversion_sequencer_inst (.SYS_CLK(sys_clk), .RST(rst),
		.S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
		.S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
		.S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
		.S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
		.S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
		.S_AXI_RREADY(r_ready), .EVENT_START(ev_start), .EVENT_RESULT_READY(ev_res), .IRQ(irq),
		.ADC_DATA(adc_data), .ADC_OVERRANGE(adc_over), .ADC_ENABLE(adc_en),
		.ADC_SAMPLE(adc_samp), .ADC_SEL(adc_sel));
	adc_core_model adc_core_model_inst (.clk(sys_clk), .enable(adc_en), .sample(adc_samp),
		.sel(adc_sel), .above_ref(over_req), .data(adc_data), .overrange(adc_over));
	function automatic logic [31:0] code(input logic [4:0] c, input logic [1:0] r);
		return {22'h0, c, 3'h5, r};
	endfunction : code
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	// Each access ends one edge after its release so the next never re-drives in the same step.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		bit aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge sys_clk);
			if (aw_ready && !aw_done) begin
				aw_done = 1;
				aw_valid <= 1'b0;
				t_aw = cyc;
			end
			if (w_ready && !w_done) begin
				w_done = 1;
				w_valid <= 1'b0;
			end
		end
		do begin @(posedge sys_clk); end while (!b_valid);
		rs = b_resp;
		b_ready <= 1'b0;
		@(posedge sys_clk);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		do begin @(posedge sys_clk); end while (!ar_ready);
		ar_valid <= 1'b0;
		do begin @(posedge sys_clk); end while (!r_valid);
		d = r_data;
		rs = r_resp;
		r_ready <= 1'b0;
		@(posedge sys_clk);
	endtask : axi_read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] rs;
		axi_write(a, d, rs);
		`CHK("bresp", `RESP_OKAY, rs)
	endtask : wr
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] d;
		logic [1:0] rs;
		axi_read(a, d, rs);
		`CHK(nm, {ex, `RESP_OKAY}, {d, rs})
	endtask : chk_rd
	task automatic wait_ev(input int tgt);
		for (int n = 0; n < 20000 && ev_cnt < tgt; n++) @(posedge sys_clk);
	endtask : wait_ev
	task automatic cfg(input int dv, dl, ln, input logic [4:0] ch, input logic [1:0] rf,
		input logic ie, input logic [31:0] ca);
		wr(`OFS_CONTROL_A, 32'h0);
		wr(`OFS_CONTROL_C, 32'(rf) << 4 | 32'(dv));
		wr(`OFS_CTRLD, 32'(dl));
		wr(`OFS_SAMPCTRL, 32'(ln));
		wr(`OFS_MUX, 32'(ch));
		wr(`OFS_IRQ_ENABLE, 32'(ie));
		wr(`OFS_CONTROL_A, ca);
		f = 2 << dv;
	endtask : cfg
	initial begin
		#900000;
		num_errors++;
		finish_test();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] rs;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		foreach (rows[i]) begin
			cfg(rows[i].dv, rows[i].dl, rows[i].ln, rows[i].ch, rows[i].rf, rows[i].ie, 32'h1);
			over_req <= rows[i].ov;
			`CHK("sel_idle", {rows[i].ch, rows[i].rf}, adc_sel)
			base = samp_cyc;
			e0 = ev_cnt;
			wr(`OFS_COMMAND, 32'h1);
			chk_rd(`OFS_COMMAND, 32'h1, "busy");
			wait_ev(e0 + 1);
			@(posedge sys_clk);
			`CHK("start_delay", 3 + f / 2, t_samp - t_aw)
			`CHK("sample_len", (2 + rows[i].dl + rows[i].ln) * f, samp_cyc - base)
			`CHK("irq", rows[i].ie, irq)
			chk_rd(`OFS_COMMAND, 32'h0, "done");
			chk_rd(`OFS_IRQ_FLAG, 32'h1, "flag");
			chk_rd(`OFS_RESULT, {22'h0, rows[i].res}, "result");
			chk_rd(`OFS_IRQ_FLAG, 32'h0, "flag_read");
			`CHK("irq_drop", 1'b0, irq)
			`CHK("pulses", e0 + 1, ev_cnt)
			over_req <= 1'b0;
			$display("row %0d finished", i);
		end
		cfg(1, 0, 0, 5'h01, 2'h0, 1'b0, 32'h1);
		e0 = ev_cnt;
		wr(`OFS_COMMAND, 32'h1);
		repeat (f) @(posedge sys_clk);
		wr(`OFS_MUX, 32'h2);
		`CHK("sel_locked", {5'h01, 2'h0}, adc_sel)
		wait_ev(e0 + 1);
		chk_rd(`OFS_RESULT, code(5'h01, 2'h0), "old_channel");
		`CHK("sel_follow", {5'h02, 2'h0}, adc_sel)
		wr(`OFS_EVCTRL, 32'h1);
		ev_start <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ev_start <= 1'b0;
		wait_ev(e0 + 2);
		chk_rd(`OFS_COMMAND, 32'h0, "event_done");
		wr(`OFS_IRQ_FLAG, 32'h1);
		chk_rd(`OFS_IRQ_FLAG, 32'h0, "flag_w1c");
		chk_rd(`OFS_RESULT, code(5'h02, 2'h0), "event_result");
		wr(`OFS_EVCTRL, 32'h0);
		$display("lock and event test finished");
		cfg(3, 0, 0, 5'h04, 2'h0, 1'b0, 32'h3);
		e0 = ev_cnt;
		wr(`OFS_COMMAND, 32'h1);
		wait_ev(e0 + 1);
		wr(`OFS_MUX, 32'h5);
		wait_ev(e0 + 2);
		`CHK("period", (13 + 0 + 0) * f, t_ev - t_ev_prev)
		chk_rd(`OFS_RESULT, code(5'h04, 2'h0), "next_old");
		wait_ev(e0 + 3);
		chk_rd(`OFS_RESULT, code(5'h05, 2'h0), "after_next");
		chk_rd(`OFS_COMMAND, 32'h1, "free_busy");
		wait_ev(e0 + 4);
		repeat (f) @(posedge sys_clk);
		wr(`OFS_CONTROL_A, 32'h0);
		repeat (300) @(posedge sys_clk);
		`CHK("no_pulse", e0 + 4, ev_cnt)
		`CHK("core_off", 1'b0, adc_en)
		chk_rd(`OFS_COMMAND, 32'h0, "abandon");
		chk_rd(`OFS_IRQ_FLAG, 32'h1, "flag_kept");
		$display("free running test finished");
		// Two accumulated 8-bit samples must give one pulse and their sum.
		wr(`OFS_CTRLB, 32'h1);
		cfg(0, 0, 0, 5'h06, 2'h0, 1'b0, 32'h5);
		e0 = ev_cnt;
		wr(`OFS_COMMAND, 32'h1);
		wait_ev(e0 + 1);
		repeat (40) @(posedge sys_clk);
		`CHK("burst_pulses", e0 + 1, ev_cnt)
		chk_rd(`OFS_RESULT, 2 * (code(5'h06, 2'h0) >> 2), "burst_sum");
		chk_rd(`OFS_STATUS, {22'h0, 1'b0, 5'h06, 2'h0, 2'h0}, "status_idle");
		$display("accumulation test finished");
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		`CHK("reset_outs", 5'h00, {aw_ready, b_valid, ev_res, irq, adc_samp})
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk_rd(`OFS_CONTROL_A, 32'h0, "ctrl_reset");
		chk_rd(`OFS_IRQ_FLAG, 32'h0, "flag_reset");
		axi_read(8'hF0, d, rs);
		`CHK("unmapped_rd", {32'h0, `RESP_SLVERR}, {d, rs})
		axi_write(8'hF0, 32'h1, rs);
		`CHK("unmapped_wr", `RESP_SLVERR, rs)
		$display("reset and map test finished");
		finish_test();
	end
endmodule : adc_conversion_sequencer_tb

// file: verification/adc_core_model.sv
// Behavioural model of the analog converter core behind the sequencer.
// Assumes the sequencer holds its selection steady while the sample phase runs.
`timescale 1ns/1ps
module adc_core_model (
	input wire logic clk,
	input wire logic enable,
	input wire logic sample,
	input wire adc_seq_pkg::sel_t sel,
	input wire logic above_ref,
	output logic [9:0] data,
	output logic overrange
);
	import adc_seq_pkg::*;
	logic sample_prev = 1'b0;
	initial data = 10'h000;
	// The code names the selection held at the end of sampling, so a lock slip shows.
	always @(posedge clk) begin
		sample_prev <= sample;
		if (!enable) begin
			data <= ~data;
		end else if (sample_prev && !sample) begin
			data <= {sel.input_channel_select, 3'h5, sel.reference_source_select};
		end
	end
	assign overrange = above_ref & enable;
endmodule : adc_core_model
